// ### logic/ccu_pkg.sv
`default_nettype none
package ccu_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam int addr_w = 8;
	localparam logic [7:0] ctrl_off = 8'h00;
	localparam logic [7:0] src_off = 8'h04;
	localparam logic [7:0] dst_off = 8'h08;
	localparam logic [7:0] flags_off = 8'h0c;
	localparam logic [7:0] result_off = 8'h10;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int ctrl_byte_bit = 5;
	localparam int flag_c_bit = 0;
	localparam int flag_v_bit = 1;
	localparam int flag_z_bit = 2;
	localparam int flag_n_bit = 3;
	localparam int result_carry_in_bit = 16;

	// ------------------------------------------------------------
	// Reset values and operand constants
	// ------------------------------------------------------------
	localparam logic [15:0] data_rst = 16'h0000;
	localparam logic [5:0] ctrl_rst = 6'h00;
	localparam logic flag_rst = 1'b0;
	localparam logic [15:0] word_most_negative = 16'h8000;
	localparam logic [15:0] word_max_pos = 16'h7fff;
	localparam logic [15:0] word_ones = 16'hffff;
	localparam logic [15:0] byte_most_negative = 16'h0080;
	localparam logic [15:0] byte_max_pos = 16'h007f;
	localparam logic [15:0] byte_ones = 16'h00ff;

	typedef enum logic [4:0] {
		op_mov, compare_op, op_bit, op_bic, op_bis, op_add, op_sub, op_xor,
		op_clr, op_com, op_inc, decrement_op, negate_op, op_adc, subtract_carry_op, op_tst,
		op_ror, op_rol, op_asr, op_asl, op_swab, op_sxt, op_mtps, op_mfps
	} op_type;

endpackage : ccu_pkg
`default_nettype wire

// ### logic/alu_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface alu_link_if;
	import ccu_pkg::*;
	op_type op;
	logic byte_mode;
	logic [15:0] src;
	logic [15:0] dst;
	logic carry;
	logic nbit;
	logic [15:0] result;
	logic carry_out;
	logic carry_in;
	modport core(input op, byte_mode, src, dst, carry, nbit,
		output result, carry_out, carry_in);
	modport user(output op, byte_mode, src, dst, carry, nbit,
		input result, carry_out, carry_in);
endinterface : alu_link_if
`default_nettype wire

// ### logic/alu_core.sv
`timescale 1ns/1ns
`default_nettype none
module alu_core
	import ccu_pkg::*;
(
	alu_link_if.core lk
);
	wire [15:0] msk = lk.byte_mode ? byte_ones : word_ones;
	wire [16:0] a = {1'b0, lk.dst & msk};
	wire [16:0] b = {1'b0, lk.src & msk};
	wire [16:0] cv = {16'h0000, lk.carry};
	logic [16:0] res17;

	// ------------------------------------------------------------
	// Function select
	// ------------------------------------------------------------
	always_comb begin
		res17 = 17'h00000;
		unique case (lk.op)
			op_mov: res17 = b;
			compare_op: res17 = b - a;
			op_add: res17 = a + b;
			op_sub: res17 = a - b;
			op_bit: res17 = a & b;
			op_bic: res17 = a & ~b;
			op_bis: res17 = a | b;
			op_xor: res17 = a ^ b;
			op_clr: res17 = 17'h00000;
			op_com: res17 = ~a;
			op_inc: res17 = a + 17'h00001;
			decrement_op: res17 = a - 17'h00001;
			negate_op: res17 = 17'h00000 - a;
			op_adc: res17 = a + cv;
			subtract_carry_op: res17 = a - cv;
			op_ror: res17 = lk.byte_mode ? {9'h000, lk.carry, a[7:1]} : {1'b0, lk.carry, a[15:1]};
			op_rol: res17 = {1'b0, a[14:0], lk.carry};
			op_asr: res17 = lk.byte_mode ? {9'h000, a[7], a[7:1]} : {1'b0, a[15], a[15:1]};
			op_asl: res17 = {1'b0, a[14:0], 1'b0};
			op_swab: res17 = {1'b0, lk.dst[7:0], lk.dst[15:8]};
			op_sxt: res17 = lk.nbit ? 17'h0ffff : 17'h00000;
			op_tst, op_mtps, op_mfps: res17 = a;
			default: res17 = a;
		endcase
	end

	// Operands are masked, so a borrow also shows at bit 8 in byte mode
	assign lk.result = res17[15:0] & msk;
	assign lk.carry_out = lk.byte_mode ? res17[8] : res17[16];
	assign lk.carry_in = (lk.op == op_inc) || (lk.op == decrement_op);

endmodule : alu_core
`default_nettype wire

// ### logic/condition_code_update.sv
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
// Function
// - Add sets V on same-sign operands with differing result; C on carry out.
// - Subtract and compare set V on opposite operands, subtrahend sign equals result.
// - Increment sets V if destination was 100000; C kept; carry-in forced one.
// - Decrement sets V if result is 100000; C kept.
// - Negate sets V if result is 100000; C clear on zero result else set.
// - Add-carry adds C; V on 077777 with C; C on 177777 with C.
// - Subtract-carry subtracts C; V set if destination was 100000.
// - Subtract-carry sets C only if destination zero and previous C one.
module condition_code_update
	import ccu_pkg::*;
(
	// Clock and reset
	input wire logic clock_in,
	input wire logic rst_in,
	// APB slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [addr_w-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// Status to the datapath
	output logic [3:0] nzvc_out,
	output logic [15:0] result_out,
	output logic alu_carry_in_out,
	output logic update_out
);
	alu_link_if lk();

	op_type op_ff;
	logic byte_ff;
	logic [15:0] src_ff;
	logic [15:0] dst_ff;
	logic n_ff;
	logic z_ff;
	logic v_ff;
	logic c_ff;
	logic [15:0] result_ff;
	logic alu_carry_in_ff;
	logic go_ff;
	logic update_ff;
	logic [31:0] prdata_ff;
	logic nxt_n;
	logic nxt_z;
	logic nxt_v;
	logic nxt_c;

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	wire hit_ctrl = paddr_in == ctrl_off;
	wire hit_src = paddr_in == src_off;
	wire hit_dst = paddr_in == dst_off;
	wire hit_flags = paddr_in == flags_off;
	wire hit_result = paddr_in == result_off;
	wire hit_any = hit_ctrl | hit_src | hit_dst | hit_flags | hit_result;
	wire access = psel_in & penable_in;
	wire setup = psel_in & ~penable_in;
	wire wr = access & pwrite_in & hit_any;
	wire wr_ctrl = wr & hit_ctrl;
	wire wr_flags = wr & hit_flags;

	assign pready_out = 1'b1;
	assign pslverr_out = access & ~hit_any;

	// ------------------------------------------------------------
	// Operand decode for the flag logic
	// ------------------------------------------------------------
	wire [15:0] msk = byte_ff ? byte_ones : word_ones;
	wire [15:0] most_negative = byte_ff ? byte_most_negative : word_most_negative;
	wire [15:0] max_pos = byte_ff ? byte_max_pos : word_max_pos;
	wire [15:0] dst_m = dst_ff & msk;
	wire [15:0] res = lk.result;
	wire res_s = byte_ff ? res[7] : res[15];
	wire src_s = byte_ff ? src_ff[7] : src_ff[15];
	wire dst_s = byte_ff ? dst_ff[7] : dst_ff[15];
	wire res_zero = res == 16'h0000;
	wire cout = lk.carry_out;

	assign lk.op = op_ff;
	assign lk.byte_mode = byte_ff;
	assign lk.src = src_ff;
	assign lk.dst = dst_ff;
	assign lk.carry = c_ff;
	assign lk.nbit = n_ff;

	alu_core u_alu (
		.lk(lk.core)
	);

	// ------------------------------------------------------------
	// Next condition codes
	// ------------------------------------------------------------
	always_comb begin
		nxt_n = n_ff;
		nxt_z = z_ff;
		nxt_v = v_ff;
		nxt_c = c_ff;
		if (wr_flags) begin
			nxt_n = pwdata_in[flag_n_bit];
			nxt_z = pwdata_in[flag_z_bit];
			nxt_v = pwdata_in[flag_v_bit];
			nxt_c = pwdata_in[flag_c_bit];
		end
		// An update wins over a software write of the same cycle for each flag the operation assigns; other flags keep the write
		if (go_ff) begin
			nxt_n = res_s;
			nxt_z = res_zero;
			unique case (op_ff)
				op_mov, op_bit, op_bic, op_bis, op_xor: begin
					nxt_v = 1'b0;
				end
				op_add: begin
					nxt_v = (src_s == dst_s) && (res_s != dst_s);
					nxt_c = cout;
				end
				op_sub: begin
					nxt_v = (src_s != dst_s) && (src_s == res_s);
					nxt_c = cout;
				end
				compare_op: begin
					// Compare subtracts the destination from the source
					nxt_v = (src_s != dst_s) && (dst_s == res_s);
					nxt_c = cout;
				end
				op_clr, op_tst, op_swab: begin
					nxt_v = 1'b0;
					nxt_c = 1'b0;
				end
				op_com: begin
					nxt_v = 1'b0;
					nxt_c = 1'b1;
				end
				op_inc: begin
					nxt_v = dst_m == most_negative;
				end
				decrement_op: begin
					nxt_v = res == most_negative;
				end
				negate_op: begin
					nxt_v = res == most_negative;
					nxt_c = ~res_zero;
				end
				op_adc: begin
					nxt_v = (dst_m == max_pos) && c_ff;
					nxt_c = (dst_m == msk) && c_ff;
				end
				subtract_carry_op: begin
					nxt_v = dst_m == most_negative;
					nxt_c = (dst_m == 16'h0000) && c_ff;
				end
				op_ror, op_asr: begin
					nxt_c = dst_ff[0];
				end
				op_rol, op_asl: begin
					nxt_c = dst_s;
				end
				op_sxt: begin
					nxt_n = n_ff;
					nxt_v = 1'b0;
					nxt_c = 1'b0;
				end
				op_mtps, op_mfps: begin
					nxt_n = dst_ff[7];
					nxt_z = ~dst_ff[7];
					nxt_v = 1'b0;
				end
				default: begin
					nxt_n = n_ff;
					nxt_z = z_ff;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Read data, taken from next values so a read never sees stale flags
	// ------------------------------------------------------------
	wire [31:0] rd_ctrl = {26'h0000000, byte_ff, op_ff};
	wire [31:0] rd_src = {16'h0000, src_ff};
	wire [31:0] rd_dst = {16'h0000, dst_ff};
	wire [31:0] rd_flags = {28'h0000000, nxt_n, nxt_z, nxt_v, nxt_c};
	wire [15:0] nxt_result = go_ff ? res : result_ff;
	wire nxt_alu_carry_in = go_ff ? lk.carry_in : alu_carry_in_ff;
	wire [31:0] rd_result = {15'h0000, nxt_alu_carry_in, nxt_result};
	wire [31:0] rd_mux = hit_ctrl ? rd_ctrl :
		hit_src ? rd_src :
		hit_dst ? rd_dst :
		hit_flags ? rd_flags :
		hit_result ? rd_result : 32'h00000000;

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			op_ff <= op_type'(ctrl_rst[4:0]);
			byte_ff <= ctrl_rst[ctrl_byte_bit];
			src_ff <= data_rst;
			dst_ff <= data_rst;
			go_ff <= 1'b0;
		end else begin
			go_ff <= wr_ctrl;
			if (wr_ctrl) begin
				op_ff <= op_type'(pwdata_in[4:0]);
				byte_ff <= pwdata_in[ctrl_byte_bit];
			end
			if (wr & hit_src)
				src_ff <= pwdata_in[15:0];
			if (wr & hit_dst)
				dst_ff <= pwdata_in[15:0];
		end
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			n_ff <= flag_rst;
			z_ff <= flag_rst;
			v_ff <= flag_rst;
			c_ff <= flag_rst;
			result_ff <= data_rst;
			alu_carry_in_ff <= 1'b0;
			update_ff <= 1'b0;
			prdata_ff <= 32'h00000000;
		end else begin
			n_ff <= nxt_n;
			z_ff <= nxt_z;
			v_ff <= nxt_v;
			c_ff <= nxt_c;
			result_ff <= nxt_result;
			alu_carry_in_ff <= nxt_alu_carry_in;
			update_ff <= go_ff;
			if (setup)
				prdata_ff <= rd_mux;
		end
	end

	assign prdata_out = prdata_ff;
	assign nzvc_out = {n_ff, z_ff, v_ff, c_ff};
	assign result_out = result_ff;
	assign alu_carry_in_out = alu_carry_in_ff;
	assign update_out = update_ff;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (rst_in);

	wire [16:0] chk_sum = {1'b0, src_ff} + {1'b0, dst_ff};
	wire [15:0] chk_diff = dst_ff - src_ff;
	wire go_word = go_ff & ~byte_ff;

	a_add_carry: assert property (go_word && op_ff == op_add |=> c_ff == $past(chk_sum[16]))
		else $error("add carry wrong");
	a_add_overflow: assert property (go_word && op_ff == op_add |=>
		v_ff == $past(src_ff[15] == dst_ff[15] && chk_sum[15] != dst_ff[15]))
		else $error("add overflow wrong");
	a_sub_overflow: assert property (go_word && op_ff == op_sub |=>
		v_ff == $past(src_ff[15] != dst_ff[15] && src_ff[15] == chk_diff[15]) && result_ff == $past(chk_diff))
		else $error("subtract overflow wrong");
	a_inc_flags: assert property (go_word && op_ff == op_inc |=>
		v_ff == $past(dst_ff == word_most_negative) && c_ff == $past(c_ff) && alu_carry_in_out)
		else $error("increment flags wrong");
	a_decrement_overflow: assert property (go_word && op_ff == decrement_op |=>
		v_ff == (result_out == word_most_negative) && c_ff == $past(c_ff))
		else $error("decrement flags wrong");
	a_negate_carry: assert property (go_ff && op_ff == negate_op |=>
		c_ff == (result_ff != 16'h0000) && z_ff == !c_ff)
		else $error("negate carry wrong");
	a_adc_flags: assert property (go_word && op_ff == op_adc |=>
		c_ff == $past(dst_ff == word_ones && c_ff) && v_ff == $past(dst_ff == word_max_pos && c_ff))
		else $error("add-carry flags wrong");
	a_subcarry_overflow: assert property (go_word && op_ff == subtract_carry_op |=>
		v_ff == $past(dst_ff == word_most_negative))
		else $error("subtract-carry overflow wrong");
	a_subcarry_carry: assert property (go_ff && op_ff == subtract_carry_op |=>
		c_ff == ($past(dst_m) == 16'h0000 && $past(c_ff)))
		else $error("subtract-carry carry wrong");
	a_logic_flags: assert property (go_word && op_ff == op_mov |=>
		!v_ff && c_ff == $past(c_ff) && n_ff == result_ff[15] && !alu_carry_in_out)
		else $error("move flags wrong");
	a_rotate_carry: assert property (go_ff && op_ff == op_rol |=>
		c_ff == $past(byte_ff ? dst_ff[7] : dst_ff[15]))
		else $error("rotate carry wrong");
	a_update_pulse: assert property (wr_ctrl |=> go_ff ##1 update_out ##1 !update_out)
		else $error("update pulse wrong");

	c_add_carry: cover property (go_ff && op_ff == op_add ##1 c_ff);
	c_subcarry_borrow: cover property (go_ff && op_ff == subtract_carry_op ##1 c_ff);
	c_byte_rotate: cover property (go_ff && byte_ff && op_ff == op_ror);
	c_inc_overflow: cover property (go_ff && op_ff == op_inc ##1 v_ff);

endmodule : condition_code_update
`default_nettype wire

// ### test/psw_model.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Status word model: keeps the codes offered with each pulse
// ------------------------------------------------------------
module psw_model (
	// Clock and reset
	input wire logic clock_in,
	input wire logic rst_in,
	// From the block
	input wire logic update_in,
	input wire logic [3:0] nzvc_in,
	input wire logic [15:0] result_in,
	// Captured state
	output logic [3:0] psw_out,
	output logic [15:0] value_out,
	output int count_out
);
	// Sampling only on the pulse shows a late or missing pulse as stale codes
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			psw_out <= 4'h0;
			value_out <= 16'h0000;
			count_out <= 0;
		end else if (update_in) begin
			psw_out <= nzvc_in;
			value_out <= result_in;
			count_out <= count_out + 1;
		end
	end
endmodule : psw_model
`default_nettype wire

// ### test/tb_condition_code_update.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin \
	checks++; \
	if ((g) !== (e)) begin \
		fails++; \
		$display("unexpected %s expected %h seen %h", n, e, g); \
	end \
end
module tb_condition_code_update
	import ccu_pkg::*;
;
	typedef struct packed {
		op_type op;
		logic byt;
		logic [3:0] pre;
		logic [15:0] src;
		logic [15:0] dst;
		logic [3:0] nzvc;
		logic [15:0] res;
	} row_type;
	logic clock_in = 1'h0;
	logic rst_in = 1'h1;
	logic psel_in = 1'h0;
	logic penable_in = 1'h0;
	logic pwrite_in = 1'h0;
	logic [7:0] paddr_in = 8'h00;
	logic [31:0] pwdata_in = 32'h0;
	logic [31:0] prdata_out;
	logic pready_out;
	logic pslverr_out;
	logic [3:0] nzvc_out;
	logic [15:0] result_out;
	logic alu_carry_in_out;
	logic update_out;
	logic [3:0] psw;
	logic [15:0] val;
	int cnt;
	int fails = 0;
	int checks = 0;
	logic [31:0] rd;
	logic er;
	// ------------------------------------------------------------
	// Cases: op, byte, preset NZVC, source, destination, NZVC, result
	// ------------------------------------------------------------
	row_type rows [0:29] = '{
		'{op_add, 1'h0, 4'h0, 16'h7fff, 16'h0001, 4'ha, 16'h8000},
		'{op_add, 1'h0, 4'h0, 16'hffff, 16'h0001, 4'h5, 16'h0000},
		'{op_add, 1'h1, 4'h0, 16'h007f, 16'h0001, 4'ha, 16'h0080},
		'{op_sub, 1'h0, 4'h0, 16'h0001, 16'h8000, 4'h2, 16'h7fff},
		'{op_sub, 1'h0, 4'h2, 16'h0001, 16'h0003, 4'h0, 16'h0002},
		'{compare_op, 1'h0, 4'h0, 16'h8000, 16'h0001, 4'h2, 16'h7fff},
		'{op_inc, 1'h0, 4'h1, 16'h0000, 16'h8000, 4'hb, 16'h8001},
		'{op_inc, 1'h1, 4'h0, 16'h0000, 16'h0080, 4'ha, 16'h0081},
		'{decrement_op, 1'h0, 4'h0, 16'h0000, 16'h8001, 4'ha, 16'h8000},
		'{negate_op, 1'h0, 4'h0, 16'h0000, 16'h8000, 4'hb, 16'h8000},
		'{negate_op, 1'h0, 4'h1, 16'h0000, 16'h0000, 4'h4, 16'h0000},
		'{op_adc, 1'h0, 4'h1, 16'h0000, 16'h7fff, 4'ha, 16'h8000},
		'{op_adc, 1'h0, 4'h1, 16'h0000, 16'hffff, 4'h5, 16'h0000},
		'{subtract_carry_op, 1'h0, 4'h0, 16'h0000, 16'h8000, 4'ha, 16'h8000},
		'{subtract_carry_op, 1'h0, 4'h1, 16'h0000, 16'h0000, 4'h9, 16'hffff},
		'{op_mov, 1'h0, 4'h3, 16'h0000, 16'h1234, 4'h5, 16'h0000},
		'{op_bit, 1'h0, 4'h3, 16'h8000, 16'h8000, 4'h9, 16'h8000},
		'{op_bic, 1'h0, 4'h2, 16'hffff, 16'hffff, 4'h4, 16'h0000},
		'{op_bis, 1'h0, 4'h1, 16'h0001, 16'h0000, 4'h1, 16'h0001},
		'{op_xor, 1'h0, 4'h2, 16'h00ff, 16'hff00, 4'h8, 16'hffff},
		'{op_ror, 1'h0, 4'h0, 16'h0000, 16'h0001, 4'h5, 16'h0000},
		'{op_ror, 1'h1, 4'h1, 16'h0000, 16'h0003, 4'h9, 16'h0081},
		'{op_rol, 1'h1, 4'h0, 16'h0000, 16'h0080, 4'h5, 16'h0000},
		'{op_asr, 1'h0, 4'h0, 16'h0000, 16'h8001, 4'h9, 16'hc000},
		'{op_asl, 1'h0, 4'h0, 16'h0000, 16'h4000, 4'h8, 16'h8000},
		'{op_clr, 1'h0, 4'h3, 16'h0000, 16'h1234, 4'h4, 16'h0000},
		'{op_com, 1'h0, 4'h2, 16'h0000, 16'h00ff, 4'h9, 16'hff00},
		'{op_tst, 1'h0, 4'h3, 16'h0000, 16'h8000, 4'h8, 16'h8000},
		'{op_sxt, 1'h0, 4'h8, 16'h0000, 16'h0000, 4'h8, 16'hffff},
		'{op_mtps, 1'h0, 4'h1, 16'h0000, 16'h0080, 4'h9, 16'h0080}
	};
	always #20 clock_in = ~clock_in;
	condition_code_update dut (.clock_in(clock_in), .rst_in(rst_in), .psel_in(psel_in),
		.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
		.prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .nzvc_out(nzvc_out),
		.result_out(result_out), .alu_carry_in_out(alu_carry_in_out), .update_out(update_out));
	psw_model model (.clock_in(clock_in), .rst_in(rst_in), .update_in(update_out), .nzvc_in(nzvc_out),
		.result_in(result_out), .psw_out(psw), .value_out(val), .count_out(cnt));
	// ------------------------------------------------------------
	// Bus and operation tasks
	// ------------------------------------------------------------
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock_in);
		psel_in <= 1'h1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clock_in);
		penable_in <= 1'h1;
		@(posedge clock_in);
		while (pready_out !== 1'h1 && n < 50) begin
			n++;
			@(posedge clock_in);
		end
		if (pready_out !== 1'h1)
			fails++;
		rd = prdata_out;
		er = pslverr_out;
		psel_in <= 1'h0;
		penable_in <= 1'h0;
	endtask : apb
	task automatic op_run(input row_type r);
		int c0;
		int n;
		n = 0;
		apb(1'h1, flags_off, {28'h0, r.pre});
		apb(1'h1, src_off, {16'h0, r.src});
		apb(1'h1, dst_off, {16'h0, r.dst});
		c0 = cnt;
		apb(1'h1, ctrl_off, {26'h0, r.byt, r.op});
		while (cnt == c0 && n < 20) begin
			n++;
			@(posedge clock_in);
		end
		if (cnt == c0)
			fails++;
		repeat (2) @(posedge clock_in);
		`CHK("updates", c0 + 1, cnt)
		`CHK("nzvc", r.nzvc, psw)
		`CHK("result", r.res, val)
		`CHK("carry_in", r.op == op_inc || r.op == decrement_op, alu_carry_in_out)
	endtask : op_run
	task automatic final_report;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : final_report
	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		repeat (4) @(posedge clock_in);
		rst_in <= 1'h0;
		apb(1'h0, flags_off, 32'h0);
		`CHK("flags_rst", 32'h0, rd)
		`CHK("nzvc_rst", 4'h0, nzvc_out)
		$display("reset test done");
		foreach (rows[i]) begin
			op_run(rows[i]);
			$display("row %0d done", i);
		end
		// Read-only result word carries the forced carry-in in bit 16
		op_run('{op_inc, 1'h0, 4'h0, 16'h0000, 16'h8000, 4'ha, 16'h8001});
		apb(1'h0, result_off, 32'h0);
		`CHK("result_reg", 32'h00018001, rd)
		apb(1'h1, result_off, 32'h0);
		apb(1'h0, result_off, 32'h0);
		`CHK("result_ro", 32'h00018001, rd)
		apb(1'h0, 8'h20, 32'h0);
		`CHK("unmapped_err", 1'h1, er)
		`CHK("unmapped_data", 32'h0, rd)
		$display("register test done");
		// Reset in mid-run must clear the codes, the result and the model
		@(posedge clock_in);
		rst_in <= 1'h1;
		repeat (2) @(posedge clock_in);
		rst_in <= 1'h0;
		@(posedge clock_in);
		`CHK("nzvc_mid_rst", 4'h0, nzvc_out)
		`CHK("result_mid_rst", 16'h0000, result_out)
		`CHK("carry_in_mid_rst", 1'h0, alu_carry_in_out)
		`CHK("psw_mid_rst", 4'h0, psw)
		$display("mid-run reset test done");
		// Second add-carry must use the carry left by the first
		apb(1'h1, flags_off, 32'h1);
		apb(1'h1, dst_off, 32'h7fff);
		apb(1'h1, ctrl_off, {27'h0, op_adc});
		apb(1'h1, ctrl_off, {27'h0, op_adc});
		repeat (4) @(posedge clock_in);
		`CHK("chain_nzvc", 4'h0, nzvc_out)
		`CHK("chain_result", 16'h7fff, result_out)
		$display("chain test done");
		final_report();
	end
	initial begin
		repeat (20000) @(posedge clock_in);
		fails++;
		final_report();
	end
endmodule : tb_condition_code_update
`default_nettype wire
